//--- hw/rbo_top.sv
// Receive byte deserializer with byte ordering and AXI4-Lite registers
//
// The address map and the AXI4-Lite interface to the registers were chosen for this implementation.
module rbo_top
  import rbo_pkg::*;
(
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write address and data
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Receive datapath side
  input  wire logic              rx_reset,
  input  wire logic [BYTE_W-1:0] rx_byte,
  input  wire logic              rx_byte_valid,
  // Fabric side
  output logic [WORD_W-1:0]      fabric_word,
  output logic                   fabric_word_valid,
  output logic                   order_done
);

  typedef struct packed {
    rbo_mode_t         mode;
    logic [SYM_W-1:0]  pat;
    logic [SYM_W-1:0]  pad;
    logic              armed;
    logic              slip;
    logic              done;
    logic [BYTE_W-1:0] hold;
    logic              aw_full;
    logic [7:0]        awaddr;
    logic              w_full;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
  } rbo_st_t;

  rbo_st_t s_q;
  rbo_st_t s_d;

  logic              ordering;
  logic [SYM_W-1:0]  mask;
  logic [SYM_W-1:0]  pat_sel;
  logic [SYM_W-1:0]  pad_sel;
  logic              msb_next;
  logic              match;
  logic [BYTE_W-1:0] byte_out;
  logic              byte_out_v;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Address decode shared by read and write
  function automatic logic addr_ok(input logic [7:0] a);
    return (a == ADDR_CTRL) || (a == ADDR_PAT) || (a == ADDR_PAD) || (a == ADDR_STAT);
  endfunction

  // Byte-lane merge of a write into an old value
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (strb[i]) r[8*i +: 8] = nw[8*i +: 8];
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Ordering datapath

  // Mode decode and masked pattern and pad
  assign ordering = s_q.mode[1];
  assign mask     = (s_q.mode == RBO_ORD9) ? MASK9 : MASK8;
  assign pat_sel  = s_q.pat & mask;
  assign pad_sel  = s_q.pad & mask;

  // Pattern seen in the upper byte slot while armed
  assign match = ordering && s_q.armed && !s_q.slip && rx_byte_valid && msb_next
                 && ((rx_byte[SYM_W-1:0] & mask) == pat_sel);

  // Byte stream into the pairing stage
  always_comb
  begin
    byte_out   = rx_byte;
    byte_out_v = rx_byte_valid;
    if (ordering)
    begin
      if (match)
        byte_out = {1'b0, pad_sel};
      else if (s_q.slip)
        byte_out = {1'b0, s_q.hold[SYM_W-1:0] & mask};
      else
        byte_out = {1'b0, rx_byte[SYM_W-1:0] & mask};
    end
    else if (s_q.mode == RBO_PASS8)
      byte_out = {2'b00, rx_byte[7:0]};
  end

  rbo_pair #(
    .BW (BYTE_W)
  ) u_pair (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .clr        (rx_reset),
    .byte_in    (byte_out),
    .byte_valid (byte_out_v),
    .word_out   (fabric_word),
    .word_valid (fabric_word_valid),
    .msb_next   (msb_next)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state: ordering control and register slave

  always_comb
  begin
    logic [31:0] cur;
    cur = 32'h0;
    s_d = s_q;
    // Hold one byte back while slipping
    if (rx_byte_valid && (match || s_q.slip))
      s_d.hold = rx_byte;
    // Write address and data taken in either order
    if (s_axi_awvalid && s_axi_awready)
    begin
      s_d.aw_full = 1'b1;
      s_d.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      s_d.w_full = 1'b1;
      s_d.wdata  = s_axi_wdata;
      s_d.wstrb  = s_axi_wstrb;
    end
    if (s_q.bvalid && s_axi_bready)
      s_d.bvalid = 1'b0;
    if (s_q.aw_full && s_q.w_full && !s_q.bvalid)
    begin
      s_d.aw_full = 1'b0;
      s_d.w_full  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = addr_ok(s_q.awaddr) ? RESP_OKAY : RESP_SLVERR;
      unique case (s_q.awaddr)
        ADDR_CTRL:
        begin
          cur       = merge({30'h0, s_q.mode}, s_q.wdata, s_q.wstrb);
          s_d.mode  = rbo_mode_t'(cur[MODE_LSB +: 2]);
          s_d.armed = 1'b1;
          s_d.slip  = 1'b0;
          s_d.done  = 1'b0;
        end
        ADDR_PAT:
        begin
          cur     = merge({23'h0, s_q.pat}, s_q.wdata, s_q.wstrb);
          s_d.pat = cur[SYM_W-1:0];
        end
        ADDR_PAD:
        begin
          cur     = merge({23'h0, s_q.pad}, s_q.wdata, s_q.wstrb);
          s_d.pad = cur[SYM_W-1:0];
        end
        default:
        begin
          cur = 32'h0;
        end
      endcase
    end
    // Pad went in: slip starts, search stops; after the control write so the set wins
    if (match)
    begin
      s_d.slip  = 1'b1;
      s_d.armed = 1'b0;
      s_d.done  = 1'b1;
    end
    // Receive reset re-arms the search
    if (rx_reset)
    begin
      s_d.armed = 1'b1;
      s_d.slip  = 1'b0;
      s_d.done  = 1'b0;
    end
    // Read channel
    if (s_q.rvalid && s_axi_rready)
      s_d.rvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = addr_ok(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      unique case (s_axi_araddr)
        ADDR_CTRL: s_d.rdata = {30'h0, s_q.mode};
        ADDR_PAT:  s_d.rdata = {23'h0, s_q.pat};
        ADDR_PAD:  s_d.rdata = {23'h0, s_q.pad};
        ADDR_STAT: s_d.rdata = {29'h0, s_q.armed, s_q.slip, s_q.done};
        default:   s_d.rdata = 32'h0;
      endcase
    end
  end

  // State register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_q       <= '0;
      s_q.mode  <= CTRL_RST;
      s_q.pat   <= PAT_RST;
      s_q.pad   <= PAD_RST;
      s_q.armed <= 1'b1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Bus outputs
  assign s_axi_awready = !s_q.aw_full;
  assign s_axi_wready  = !s_q.w_full;
  assign s_axi_bvalid  = s_q.bvalid;
  assign s_axi_bresp   = s_q.bresp;
  assign s_axi_arready = !s_q.rvalid;
  assign s_axi_rvalid  = s_q.rvalid;
  assign s_axi_rdata   = s_q.rdata;
  assign s_axi_rresp   = s_q.rresp;
  assign order_done    = s_q.done;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_half_rate_out: assert property (fabric_word_valid |=> !fabric_word_valid)
    else $error("word valid on two cycles in a row");
  a_pair_msb_byte: assert property (rx_byte_valid && msb_next && !ordering && !rx_reset
    |=> fabric_word_valid && fabric_word[19:10] == $past(byte_out))
    else $error("passed byte missing from upper half");
  a_pass_no_pad: assert property (!ordering |-> !match && byte_out == (s_q.mode == RBO_PASS8
    ? {2'b00, rx_byte[7:0]} : rx_byte))
    else $error("pass mode altered the stream");
  a_pad_in_msb: assert property (match && !rx_reset
    |=> fabric_word_valid && fabric_word[19:10] == {1'b0, $past(pad_sel)})
    else $error("pad byte not in upper half");
  a_pattern_lsb: assert property (match ##1 (rx_byte_valid && !rx_reset && $stable(pat_sel))
    |=> !fabric_word_valid ##1 1'b1)
    else $error("pattern byte not held for low half");
  a_single_pad: assert property (s_q.slip && !rx_reset && !(s_q.aw_full && s_q.w_full
    && !s_q.bvalid && s_q.awaddr == ADDR_CTRL) |=> s_q.slip && !match)
    else $error("second pad insertion");
  a_ord8_match: assert property (s_q.mode == RBO_ORD8 && s_q.armed && !s_q.slip
    && rx_byte_valid && msb_next && rx_byte[7:0] == s_q.pat[7:0] |-> match)
    else $error("8-bit pattern missed");
  a_ctl_flag: assert property (s_q.mode == RBO_ORD9 && rx_byte[8] != s_q.pat[8] |-> !match)
    else $error("control flag ignored in 9-bit mode");
  a_rearm_reset: assert property (rx_reset |=> s_q.armed && !order_done && !s_q.slip)
    else $error("search not re-armed");
  a_done_cause: assert property ($rose(order_done) |-> $past(match))
    else $error("done without a correction");

  c_pad_insert: cover property (match ##1 fabric_word_valid);
  c_done_word: cover property ($rose(order_done) ##[1:4] fabric_word_valid);
  c_pass_word: cover property (!ordering && fabric_word_valid);
  c_write_resp: cover property (s_axi_bvalid && s_axi_bready);

endmodule

//--- hw/rbo_pkg.sv
// Constants and types shared by the receive byte ordering block
//
// Summary of operation
// - Words leave at no more than half the byte rate, each twice as wide as one byte.
// - One 8- or 10-bit byte is taken per cycle and two in a row form a 16- or 20-bit word.
// - After a receive reset the byte pairing phase restarts at the low slot and may split a sent word.
// - In ordering modes, while the search is armed, each byte in the upper slot is compared with the programmed ordering pattern.
// - A pattern found in the upper byte slot makes one pad byte go in, moving it to the low slot.
// - The 8-bit ordering mode matches and pads with 8-bit values.
// - The 9-bit ordering mode matches and pads with 9-bit values.
// - In 9-bit mode bit 8 is the control-or-data flag and is matched and sent as such.
// - In the plain modes words pass through with no search and no pad.
package rbo_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PAT  = 8'h04;
  localparam logic [7:0] ADDR_PAD  = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0c;

  // Field positions and widths
  localparam int MODE_LSB      = 0;
  localparam int SYM_W         = 9;
  localparam int STAT_DONE_BIT = 0;
  localparam int STAT_SLIP_BIT = 1;
  localparam int STAT_ARM_BIT  = 2;

  // Byte and word widths
  localparam int BYTE_W = 10;
  localparam int WORD_W = 20;

  // Operating modes
  typedef enum logic [1:0] {
    RBO_PASS8  = 2'h0,
    RBO_PASS10 = 2'h1,
    RBO_ORD8   = 2'h2,
    RBO_ORD9   = 2'h3
  } rbo_mode_t;

  // Reset values
  localparam rbo_mode_t      CTRL_RST = RBO_PASS8;
  localparam logic [SYM_W-1:0] PAT_RST  = 9'h000;
  localparam logic [SYM_W-1:0] PAD_RST  = 9'h000;

  // Symbol masks per ordering width
  localparam logic [SYM_W-1:0] MASK8 = 9'h0ff;
  localparam logic [SYM_W-1:0] MASK9 = 9'h1ff;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

//--- hw/rbo_pair.sv
// Byte pairing stage: two bytes in, one double-width word out
module rbo_pair
  import rbo_pkg::*;
#(
  parameter int BW = BYTE_W
)
(
  // Clock and reset
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic          clr,
  // Byte stream in
  input  wire logic [BW-1:0] byte_in,
  input  wire logic          byte_valid,
  // Word stream out
  output logic [2*BW-1:0]    word_out,
  output logic               word_valid,
  output logic               msb_next
);

  // Refuse byte widths too narrow to carry a 9-bit symbol
  if (BW < SYM_W)
  begin : g_bw_check
    $error("rbo_pair: byte width too small");
  end

  typedef struct packed {
    logic [BW-1:0]   lo;
    logic            phase;
    logic [2*BW-1:0] word;
    logic            vld;
  } rbo_pair_st_t;

  rbo_pair_st_t s_q;
  rbo_pair_st_t s_d;

  // First byte goes low, second high; phase after reset is the arrival order
  always_comb
  begin
    s_d     = s_q;
    s_d.vld = 1'b0;
    if (clr)
    begin
      s_d.phase = 1'b0;
    end
    else if (byte_valid)
    begin
      if (s_q.phase)
      begin
        s_d.word  = {byte_in, s_q.lo};
        s_d.vld   = 1'b1;
        s_d.phase = 1'b0;
      end
      else
      begin
        s_d.lo    = byte_in;
        s_d.phase = 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign word_out   = s_q.word;
  assign word_valid = s_q.vld;
  assign msb_next   = s_q.phase;

endmodule

//--- tb/rbo_src.sv
// Upstream byte source model: sends two-byte words, low byte first
module rbo_src
  import rbo_pkg::*;
(
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // Word request from the bench
  input  wire logic [WORD_W-1:0] tx_word,
  input  wire logic              tx_go,
  input  wire logic              tx_one,
  output logic                   tx_ready,
  // Byte stream to the block
  output logic [BYTE_W-1:0]      rx_byte,
  output logic                   rx_byte_valid
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [1:0]        cnt_q;
  logic [BYTE_W-1:0] hi_q;

  // Ready only between words
  assign tx_ready = (cnt_q == 2'h0);

  // Low byte, high byte back to back, then an idle cycle with a changing bus
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_q         <= 2'h0;
      rx_byte_valid <= 1'b0;
      rx_byte       <= '0;
    end
    else if (cnt_q == 2'h0 && tx_go)
    begin
      rx_byte       <= tx_word[BYTE_W-1:0];
      hi_q          <= tx_word[WORD_W-1:BYTE_W];
      rx_byte_valid <= 1'b1;
      cnt_q         <= tx_one ? 2'h2 : 2'h1;
    end
    else if (cnt_q == 2'h1)
    begin
      rx_byte <= hi_q;
      cnt_q   <= 2'h2;
    end
    else
    begin
      rx_byte_valid <= 1'b0;
      rx_byte       <= ~rx_byte;
      cnt_q         <= 2'h0;
    end
  end
endmodule

//--- tb/tb_rbo_top.sv
// Self-checking bench for the receive byte ordering block
module tb_rbo_top;
  import rbo_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  logic              aclk, aresetn, rx_reset, rx_byte_valid, fabric_word_valid, order_done;
  logic              awvalid, awready, wvalid, wready, bvalid, bready;
  logic              arvalid, arready, rvalid, rready, tx_go, tx_one, tx_ready;
  logic [7:0]        awaddr, araddr;
  logic [31:0]       wdata, rdata;
  logic [3:0]        wstrb;
  logic [1:0]        bresp, rresp;
  logic [BYTE_W-1:0] rx_byte, lo_m, held_m, pat_m, pad_m, mk, b, c;
  logic [WORD_W-1:0] tx_word, fabric_word;
  logic [WORD_W-1:0] exq[$];
  logic              ph_m, slip_m, arm_m, done_m, vprev;
  rbo_mode_t         mode_m;
  int                err_count, num_checks, seed;

  rbo_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .rx_reset(rx_reset), .rx_byte(rx_byte), .rx_byte_valid(rx_byte_valid),
    .fabric_word(fabric_word), .fabric_word_valid(fabric_word_valid), .order_done(order_done));

  rbo_src SRC (.aclk(aclk), .aresetn(aresetn), .tx_word(tx_word), .tx_go(tx_go),
    .tx_one(tx_one), .tx_ready(tx_ready), .rx_byte(rx_byte), .rx_byte_valid(rx_byte_valid));

  ////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  initial
  begin
    repeat (5000) @(posedge aclk);
    err_count++;
    finish_test();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compare, verdict and expected-value helpers
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Byte width kept by each mode
  function automatic logic [BYTE_W-1:0] fmask(input rbo_mode_t m);
    if (m == RBO_PASS10)
      return 10'h3ff;
    if (m == RBO_ORD9)
      return 10'h1ff;
    return 10'h0ff;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Reference pairing model and output monitor
  always @(posedge aclk)
  begin
    if (aresetn === 1'b1 && fabric_word_valid === 1'b1)
    begin
      chk("valid_gap", vprev, 1'b0);
      chk("fabric_word", fabric_word, exq.size() > 0 ? exq.pop_front() : 'x);
    end
    vprev = fabric_word_valid;
    if (!aresetn || rx_reset)
    begin
      ph_m   = 1'b0;
      slip_m = 1'b0;
      arm_m  = 1'b1;
      done_m = 1'b0;
    end
    else if (rx_byte_valid)
    begin
      b = rx_byte & mk;
      if (mode_m[1] && arm_m && !slip_m && ph_m && b == (pat_m & mk))
      begin
        exq.push_back({pad_m & mk, lo_m});
        held_m = b;
        slip_m = 1'b1;
        arm_m  = 1'b0;
        done_m = 1'b1;
        ph_m   = 1'b0;
      end
      else
      begin
        c = slip_m ? held_m : b;
        if (slip_m)
          held_m = b;
        if (!ph_m)
          lo_m = c;
        else
          exq.push_back({c, lo_m});
        ph_m = !ph_m;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite master and byte source tasks
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ad;
    logic dd;
    ad = 1'b0;
    dd = 1'b0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!(ad && dd))
    begin
      @(posedge aclk);
      if (!ad && awready === 1'b1)
      begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (!dd && wready === 1'b1)
      begin
        dd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    chk("bresp", bresp, er);
    bready <= 1'b0;
  endtask

  task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    chk("rdata", rdata, ed);
    chk("rresp", rresp, er);
    rready <= 1'b0;
  endtask

  task automatic snd(input logic [WORD_W-1:0] w, input logic one);
    @(posedge aclk);
    while (tx_ready !== 1'b1) @(posedge aclk);
    tx_word <= w;
    tx_one  <= one;
    tx_go   <= 1'b1;
    @(posedge aclk);
    tx_go <= 1'b0;
  endtask

  // One stream: program, restart pairing, optional stray byte, six words
  task automatic run(input rbo_mode_t m, input logic s);
    logic [WORD_W-1:0] w;
    pat_m = {1'b0, 9'($random(seed))};
    pad_m = {1'b0, 9'($random(seed))};
    axw(ADDR_PAT, {22'h0, pat_m}, RESP_OKAY);
    axw(ADDR_PAD, {22'h0, pad_m}, RESP_OKAY);
    axw(ADDR_CTRL, {30'h0, m}, RESP_OKAY);
    mode_m = m;
    mk = fmask(m);
    @(posedge aclk);
    rx_reset <= 1'b1;
    @(posedge aclk);
    rx_reset <= 1'b0;
    @(posedge aclk);
    chk("done_clear", order_done, 1'b0);
    if (s)
      snd(20'($random(seed)), 1'b1);
    for (int i = 0; i < 6; i++)
    begin
      w = 20'($random(seed));
      if (i == 2)
        w[BYTE_W-1:0] = pat_m;
      snd(w, 1'b0);
    end
    repeat (8) @(posedge aclk);
    chk("leftover", exq.size(), 0);
    chk("order_done", order_done, done_m);
    axr(ADDR_STAT, {29'h0, arm_m, slip_m, done_m}, RESP_OKAY);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    seed = 80;
    {aresetn, rx_reset, awvalid, wvalid, bready, arvalid, rready, tx_go, tx_one} = '0;
    {awaddr, araddr, wdata, tx_word} = '0;
    wstrb = 4'hf;
    mode_m = RBO_PASS8;
    mk = 10'h0ff;
    vprev = 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    axr(ADDR_CTRL, 32'h0, RESP_OKAY);
    axr(ADDR_PAT, 32'h0, RESP_OKAY);
    axr(ADDR_PAD, 32'h0, RESP_OKAY);
    axr(ADDR_STAT, 32'h4, RESP_OKAY);
    axw(8'h10, 32'h3, RESP_SLVERR);
    axr(8'h10, 32'h0, RESP_SLVERR);
    // Byte-lane strobe: only the low lane of the pattern may change
    wstrb <= 4'h1;
    axw(ADDR_PAT, 32'h1ff, RESP_OKAY);
    wstrb <= 4'hf;
    axr(ADDR_PAT, 32'h0ff, RESP_OKAY);
    axr(ADDR_CTRL, 32'h0, RESP_OKAY);
    for (int m = 0; m < 4; m++)
    begin
      run(rbo_mode_t'(m), 1'b1);
      run(rbo_mode_t'(m), 1'b0);
    end
    // Mid-run reset brings back the register defaults and a fresh search
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    axr(ADDR_CTRL, 32'h0, RESP_OKAY);
    axr(ADDR_STAT, 32'h4, RESP_OKAY);
    run(RBO_ORD8, 1'b1);
    finish_test();
  end
endmodule
